// [src/qtimer_pkg.sv]
package qtimer_pkg;

	////////////////////////////////////////////////////////////////////////
	// register map, byte addresses on the 32-bit bus
	localparam logic [11:0] ADDR_COUNTER = 12'h300;
	localparam logic [11:0] ADDR_CONTROL = 12'h304;
	localparam logic [11:0] ADDR_STATUS = 12'h308;
	localparam logic [11:0] ADDR_RELOAD = 12'h30C;
	localparam logic [11:0] ADDR_MODE = 12'h338;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	////////////////////////////////////////////////////////////////////////
	// field encodings and reset values
	localparam logic [1:0] MODE_EVENT = 2'h1;
	localparam logic [1:0] MODE_ONESHOT = 2'h2;

	localparam logic [1:0] TRIG_PIN = 2'h0;
	localparam logic [1:0] TRIG_TIMER_B = 2'h1;
	localparam logic [1:0] TRIG_PREV = 2'h2;
	localparam logic [1:0] TRIG_NEXT = 2'h3;

	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
	localparam logic [15:0] COUNT_ZERO = 16'h0000;
	localparam logic [15:0] COUNT_ONE = 16'h0001;
	localparam logic [15:0] ONESHOT_READ_VALUE = 16'h0000;
	localparam logic [15:0] RELOAD_RESET = 16'h0000;

	localparam int CHANNEL_NORMAL = 2;
	localparam int CHANNEL_ZPHASE = 3;
	localparam int CHANNEL_X4 = 4;

	// count-source divide ratios, selected by a 2-bit field
	localparam logic [7:0] DIV_SEL0 = 8'h01;
	localparam logic [7:0] DIV_SEL1 = 8'h08;
	localparam logic [7:0] DIV_SEL2 = 8'h20;
	localparam logic [7:0] DIV_SEL3 = 8'h40;

	////////////////////////////////////////////////////////////////////////
	// register layouts
	typedef struct packed {
		logic decoding_select;
		logic count_type_select;
		logic width_select;
		logic trigger_select;
		logic trigger_edge_select;
		logic pulse_output_select;
		logic [1:0] operation_mode;
	} mode_t;

	typedef struct packed {
		logic [1:0] alt_source;
		logic source_extension_bit;
		logic [1:0] trigger_source;
		logic output_polarity_bit;
		logic edge_polarity_bit;
		logic two_phase_enable;
		logic zphase_init_enable;
		logic oneshot_start_bit;
		logic run_enable_bit;
	} control_t;

	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [10:0] CONTROL_RESET = 11'h0;

	// synchronised pins
	typedef struct packed {
		logic zphase;
		logic out_pin;
		logic in_pin;
	} pins_t;

endpackage

// [src/qtimer_prescaler.sv]
`timescale 1ns/100ps
`default_nettype none

// count-source divider: one-cycle tick every selected ratio of clocks
module qtimer_prescaler #(
	parameter logic [7:0] DIV0 = qtimer_pkg::DIV_SEL0,
	parameter logic [7:0] DIV1 = qtimer_pkg::DIV_SEL1,
	parameter logic [7:0] DIV2 = qtimer_pkg::DIV_SEL2,
	parameter logic [7:0] DIV3 = qtimer_pkg::DIV_SEL3
) (
	// system
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// control
	input wire logic [1:0] sel_i,
	output logic tick_o
);

	logic [7:0] div_q;
	logic [7:0] ratio;
	logic wrap;

	if (DIV0 == 8'h00 || DIV1 == 8'h00 || DIV2 == 8'h00 || DIV3 == 8'h00) begin : g_bad_div
		$error("qtimer_prescaler: divide ratios must be non-zero");
	end

	assign ratio = (sel_i == 2'h0) ? DIV0 : (sel_i == 2'h1) ? DIV1 : (sel_i == 2'h2) ? DIV2 : DIV3;
	assign wrap = (div_q >= ratio - 8'h01);

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			div_q <= 8'h00;
			tick_o <= 1'b0;
		end else begin
			div_q <= wrap ? 8'h00 : div_q + 8'h01;
			tick_o <= wrap;
		end
	end

endmodule // qtimer_prescaler

`default_nettype wire

// [src/qtimer_sync.sv]
`timescale 1ns/100ps
`default_nettype none

// two-stage synchroniser, one per bit
module qtimer_sync #(
	parameter int WIDTH = 3
) (
	// system
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// data
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);

	logic [WIDTH-1:0] meta_q;

	if (WIDTH < 1) begin : g_bad_width
		$error("qtimer_sync: WIDTH must be at least 1");
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			meta_q <= '0;
			q_o <= '0;
		end else begin
			meta_q <= d_i;
			q_o <= meta_q;
		end
	end

endmodule // qtimer_sync

`default_nettype wire

// [src/quad_oneshot_timer.sv]
`timescale 1ns/100ps
`default_nettype none

// Function
// - two-phase mode counts both pins; their phase sets up or down
// - overflow or underflow reloads in reload type, wraps in free-run type
// - reload type gives FFFFh-n+1 counts up and n+1 counts down
// - run-enable starts and stops; every overflow or underflow raises an interrupt
// - counter write while stopped loads both; while running only the reload register
// - decoding select works only on the third channel; second normal, fourth by four
// - normal decoding counts input-pin edges while output pin is high
// - multiply-by-4 counts every edge, direction from input-pin edge while output high
// - Z-phase clears counter, third channel, free-run and multiply-by-4 only
// - Z edge picked by polarity bit; clear happens at next count timing
// - overflow coinciding with Z clear gives two interrupt requests back to back
// - one-shot counts down, reloads and stops at zero; retrigger reloads
// - one-shot pulse lasts n periods; setting zero never runs
// - one-shot starts on pin edge, timer events or software start bit
// - one-shot interrupt at zero; clearing run-enable also stops it
// - one-shot counter read returns a fixed undefined value
// - one-shot write before first count tick loads both, later only reload
// - pulse output low when stopped, high when counting, inverted by polarity
// - trigger edge select works only with trigger select and pin source
// - one-shot source select b7-b6 used only when extension bit is zero
module quad_oneshot_timer #(
	parameter int CHANNEL_INDEX = qtimer_pkg::CHANNEL_ZPHASE
) (
	// system
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// axi4-lite write address and data
	input wire logic [11:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	// axi4-lite read
	input wire logic [11:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// pins
	input wire logic channel_input_pin_i,
	input wire logic channel_output_pin_i,
	input wire logic zphase_pin_i,
	output logic channel_output_pin_o,
	output logic channel_output_pin_oe_o,
	// neighbouring timer events, same clock
	input wire logic timer_b_event_i,
	input wire logic prev_channel_event_i,
	input wire logic next_channel_event_i,
	// interrupt request, one-cycle pulse
	output logic irq_o
);

	if (CHANNEL_INDEX < qtimer_pkg::CHANNEL_NORMAL || CHANNEL_INDEX > qtimer_pkg::CHANNEL_X4)
	begin : g_bad_channel
		$error("quad_oneshot_timer: CHANNEL_INDEX must be 2, 3 or 4");
	end

	typedef enum logic [2:0] {
		OS_STOP = 3'b001,
		OS_ARMED = 3'b010,
		OS_COUNT = 3'b100
	} os_state_t;

	function automatic logic [4:0] reg_sel(input logic [11:0] addr);
		reg_sel = {addr == qtimer_pkg::ADDR_MODE, addr == qtimer_pkg::ADDR_RELOAD,
			addr == qtimer_pkg::ADDR_STATUS, addr == qtimer_pkg::ADDR_CONTROL,
			addr == qtimer_pkg::ADDR_COUNTER};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// state
	qtimer_pkg::mode_t mode_q;
	qtimer_pkg::control_t ctrl_q;
	qtimer_pkg::pins_t pin_s, pin_q;
	os_state_t os_q, os_d;
	logic [15:0] cnt_q, cnt_d, reload_q;
	logic dir_q, zpend_q, irq_pend_q, sw_start_q;
	logic aw_held_q, w_held_q;
	logic [11:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisation and edges
	// two-flop synchronisers
	qtimer_sync #(
		.WIDTH(3)
	) u_sync (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.d_i({zphase_pin_i, channel_output_pin_i, channel_input_pin_i}),
		.q_o(pin_s)
	);

	wire a_rise = pin_s.in_pin & ~pin_q.in_pin;
	wire a_fall = ~pin_s.in_pin & pin_q.in_pin;
	wire a_edge = a_rise | a_fall;
	wire b_edge = pin_s.out_pin ^ pin_q.out_pin;
	wire b_hi = pin_s.out_pin;
	wire z_rise = pin_s.zphase & ~pin_q.zphase;
	wire z_fall = ~pin_s.zphase & pin_q.zphase;

	////////////////////////////////////////////////////////////////////////
	// two-phase decoding
	wire run = ctrl_q.run_enable_bit;
	wire free = mode_q.count_type_select;
	wire two_phase = (mode_q.operation_mode == qtimer_pkg::MODE_EVENT) && ctrl_q.two_phase_enable;
	wire oneshot = (mode_q.operation_mode == qtimer_pkg::MODE_ONESHOT);
	wire x4 = (CHANNEL_INDEX == qtimer_pkg::CHANNEL_X4)
		|| (CHANNEL_INDEX == qtimer_pkg::CHANNEL_ZPHASE && mode_q.decoding_select);
	// normal decoding counts input-pin edges while output pin high
	wire norm_evt = b_hi & a_edge;
	// every edge of both phases, direction latched from input-pin edge
	wire x4_evt = a_edge | b_edge;
	wire x4_up = (a_edge & b_hi) ? a_rise : dir_q;
	wire qd_evt = two_phase & run & (x4 ? x4_evt : norm_evt);
	wire qd_up = x4 ? x4_up : a_rise;
	wire at_limit = qd_up ? (cnt_q == qtimer_pkg::COUNT_MAX) : (cnt_q == qtimer_pkg::COUNT_ZERO);
	wire [15:0] wrap_val = qd_up ? qtimer_pkg::COUNT_ZERO : qtimer_pkg::COUNT_MAX;
	wire [15:0] step_val = qd_up ? cnt_q + qtimer_pkg::COUNT_ONE : cnt_q - qtimer_pkg::COUNT_ONE;
	// reload type or free-run wrap; gives n-dependent count lengths
	wire [15:0] qd_next = at_limit ? (free ? wrap_val : reload_q) : step_val;

	wire z_allowed = (CHANNEL_INDEX == qtimer_pkg::CHANNEL_ZPHASE) && two_phase && free && x4
		&& ctrl_q.zphase_init_enable;
	// edge by polarity, clear at next count timing
	wire z_edge = ctrl_q.edge_polarity_bit ? z_rise : z_fall;
	wire z_clear = qd_evt & zpend_q;
	// an edge landing with the clearing count stays pending
	wire zpend_d = z_allowed & (z_edge | (zpend_q & ~qd_evt));

	////////////////////////////////////////////////////////////////////////
	// one-shot triggers and count source
	// b7-b6 pick the source only while the extension bit is zero
	wire [1:0] src_sel = ctrl_q.source_extension_bit ? ctrl_q.alt_source
		: {mode_q.decoding_select, mode_q.count_type_select};
	logic src_tick;

	qtimer_prescaler u_div (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.sel_i(src_sel),
		.tick_o(src_tick)
	);

	// edge select applies to the pin source only
	wire pin_trig = mode_q.trigger_edge_select ? a_rise : a_fall;
	wire hw_trig = (ctrl_q.trigger_source == qtimer_pkg::TRIG_PIN) ? pin_trig
		: (ctrl_q.trigger_source == qtimer_pkg::TRIG_TIMER_B) ? timer_b_event_i
		: (ctrl_q.trigger_source == qtimer_pkg::TRIG_PREV) ? prev_channel_event_i
		: next_channel_event_i;
	// hardware or software start with run-enable set
	wire os_trig = oneshot & run & ((mode_q.trigger_select & hw_trig) | sw_start_q);
	wire os_running = (os_q != OS_STOP);
	wire os_last = (cnt_q[15:1] == 15'h0);
	wire os_done = oneshot & run & os_running & ~os_trig & src_tick & os_last;

	////////////////////////////////////////////////////////////////////////
	// bus decode
	wire aw_hs = s_axi_awvalid_i & s_axi_awready_o;
	wire w_hs = s_axi_wvalid_i & s_axi_wready_o;
	wire ar_hs = s_axi_arvalid_i & s_axi_arready_o;
	wire wr_do = aw_held_q & w_held_q & ~s_axi_bvalid_o;
	wire [4:0] wsel = reg_sel(awaddr_q);
	wire [4:0] rsel = reg_sel(s_axi_araddr_i);
	wire cnt_wr = wr_do & wsel[0] & (wstrb_q[1:0] != 2'b00);
	wire [15:0] wr_cnt_val = {wstrb_q[1] ? wdata_q[15:8] : reload_q[15:8],
		wstrb_q[0] ? wdata_q[7:0] : reload_q[7:0]};
	// two-phase write reaches the counter only while stopped
	// one-shot write reaches the counter until the first tick
	wire cnt_load = oneshot ? (os_q != OS_COUNT) : ~run;
	wire aw_held_d = (aw_held_q | aw_hs) & ~wr_do;
	wire w_held_d = (w_held_q | w_hs) & ~wr_do;
	wire bvalid_d = (s_axi_bvalid_o & ~s_axi_bready_i) | wr_do;
	wire rvalid_d = (s_axi_rvalid_o & ~s_axi_rready_i) | ar_hs;
	qtimer_pkg::control_t ctrl_rd;
	always_comb begin
		ctrl_rd = ctrl_q;
		ctrl_rd.oneshot_start_bit = 1'b0;
	end
	wire [15:0] cnt_rd = oneshot ? qtimer_pkg::ONESHOT_READ_VALUE : cnt_q;
	wire [31:0] rd_val = rsel[0] ? {16'h0000, cnt_rd}
		: rsel[1] ? {21'h0, ctrl_rd}
		: rsel[2] ? {29'h0, zpend_q, dir_q, os_running | (two_phase & run)}
		: rsel[3] ? {16'h0000, reload_q}
		: rsel[4] ? {24'h000000, mode_q}
		: 32'h00000000;

	////////////////////////////////////////////////////////////////////////
	// counter and one-shot sequencing
	always_comb begin
		cnt_d = cnt_q;
		os_d = os_q;
		if (oneshot) begin
			unique case (os_q)
				OS_STOP: begin
					if (os_trig && reload_q != qtimer_pkg::COUNT_ZERO) begin
						cnt_d = reload_q;
						os_d = OS_ARMED;
					end
				end
				OS_ARMED, OS_COUNT: begin
					if (!run) begin
						os_d = OS_STOP;
					end else if (os_trig) begin
						cnt_d = reload_q;
						os_d = (reload_q == qtimer_pkg::COUNT_ZERO) ? OS_STOP : os_q;
					// reload and stop on reaching zero
					end else if (os_done) begin
						cnt_d = reload_q;
						os_d = OS_STOP;
					end else if (src_tick) begin
						cnt_d = cnt_q - qtimer_pkg::COUNT_ONE;
						os_d = OS_COUNT;
					end
				end
				default: os_d = OS_STOP;
			endcase
		end else begin
			os_d = OS_STOP;
			// clear to zero at the count timing
			if (z_clear) begin
				cnt_d = qtimer_pkg::COUNT_ZERO;
			end else if (qd_evt) begin
				cnt_d = qd_next;
			end
		end
		if (cnt_wr && cnt_load) begin
			cnt_d = wr_cnt_val;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pin_q <= '0;
			cnt_q <= qtimer_pkg::COUNT_ZERO;
			os_q <= OS_STOP;
			dir_q <= 1'b0;
			zpend_q <= 1'b0;
			irq_pend_q <= 1'b0;
			irq_o <= 1'b0;
			channel_output_pin_o <= 1'b0;
			channel_output_pin_oe_o <= 1'b0;
		end else begin
			pin_q <= pin_s;
			cnt_q <= cnt_d;
			os_q <= os_d;
			if (qd_evt) begin
				dir_q <= qd_up;
			end
			zpend_q <= zpend_d;
			irq_pend_q <= z_clear & at_limit;
			// interrupt on overflow or underflow; at one-shot zero
			irq_o <= (qd_evt & at_limit) | irq_pend_q | os_done;
			// pulse level from running state and polarity
			channel_output_pin_o <= (os_d != OS_STOP) ^ ctrl_q.output_polarity_bit;
			channel_output_pin_oe_o <= oneshot & mode_q.pulse_output_select;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register file and bus slave
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			mode_q <= qtimer_pkg::MODE_RESET;
			ctrl_q <= qtimer_pkg::CONTROL_RESET;
			reload_q <= qtimer_pkg::RELOAD_RESET;
			sw_start_q <= 1'b0;
		end else begin
			sw_start_q <= wr_do & wsel[1] & wstrb_q[0] & wdata_q[1];
			if (cnt_wr) begin
				reload_q <= wr_cnt_val;
			end
			if (wr_do && wsel[4] && wstrb_q[0]) begin
				mode_q <= wdata_q[7:0];
			end
			if (wr_do && wsel[1]) begin
				if (wstrb_q[0]) begin
					ctrl_q[7:0] <= {wdata_q[7:2], 1'b0, wdata_q[0]};
				end
				if (wstrb_q[1]) begin
					ctrl_q[10:8] <= wdata_q[10:8];
				end
			end
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awaddr_q <= 12'h000;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			s_axi_awready_o <= 1'b0;
			s_axi_wready_o <= 1'b0;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= qtimer_pkg::RESP_OKAY;
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h00000000;
			s_axi_rresp_o <= qtimer_pkg::RESP_OKAY;
		end else begin
			aw_held_q <= aw_held_d;
			w_held_q <= w_held_d;
			if (aw_hs) begin
				awaddr_q <= {s_axi_awaddr_i[11:2], 2'b00};
			end
			if (w_hs) begin
				wdata_q <= s_axi_wdata_i;
				wstrb_q <= s_axi_wstrb_i;
			end
			s_axi_awready_o <= ~aw_held_d;
			s_axi_wready_o <= ~w_held_d;
			s_axi_bvalid_o <= bvalid_d;
			if (wr_do) begin
				s_axi_bresp_o <= (wsel != 5'h00) ? qtimer_pkg::RESP_OKAY : qtimer_pkg::RESP_SLVERR;
			end
			s_axi_rvalid_o <= rvalid_d;
			s_axi_arready_o <= ~rvalid_d;
			if (ar_hs) begin
				s_axi_rdata_o <= rd_val;
				s_axi_rresp_o <= (rsel != 5'h00) ? qtimer_pkg::RESP_OKAY : qtimer_pkg::RESP_SLVERR;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	chk_quad_step_count: assert property (
		qd_evt && !at_limit && !z_clear && !cnt_wr
		|=> cnt_q == ($past(qd_up) ? $past(cnt_q) + 16'h0001 : $past(cnt_q) - 16'h0001))
		else $error("two-phase step wrong");

	chk_normal_decode_dir: assert property (
		two_phase && run && !x4 && b_hi && a_rise |-> qd_evt && qd_up)
		else $error("normal decode missed an up count");

	chk_x4_every_edge: assert property (
		two_phase && run && x4 && (a_edge || b_edge) |-> qd_evt)
		else $error("multiply-by-4 missed an edge");

	chk_reload_at_limit: assert property (
		qd_evt && at_limit && !free && !z_clear && !cnt_wr |=> cnt_q == $past(reload_q))
		else $error("reload type did not reload");

	chk_free_run_wrap: assert property (
		qd_evt && at_limit && free && !z_clear && !cnt_wr |=> cnt_q == $past(wrap_val))
		else $error("free-run did not wrap");

	chk_limit_irq: assert property (
		qd_evt && at_limit |=> irq_o)
		else $error("no interrupt on overflow or underflow");

	chk_running_write_reload: assert property (
		two_phase && run && cnt_wr && !qd_evt
		|=> cnt_q == $past(cnt_q) && reload_q == $past(wr_cnt_val))
		else $error("running write touched the counter");

	chk_zphase_clear: assert property (
		z_clear && !cnt_wr |=> cnt_q == 16'h0000)
		else $error("Z-phase did not clear");

	chk_double_irq: assert property (
		z_clear && at_limit |=> irq_o ##1 irq_o)
		else $error("coincident clear lacks second request");

	chk_oneshot_end: assert property (
		os_done && !cnt_wr |=> os_q == OS_STOP && irq_o && cnt_q == $past(reload_q))
		else $error("one-shot did not reload and stop");

	chk_zero_never_runs: assert property (
		oneshot && os_q == OS_STOP && reload_q == 16'h0000 |=> os_q == OS_STOP)
		else $error("zero setting started the one-shot");

	chk_pulse_level: assert property (
		oneshot && mode_q.pulse_output_select
		|=> channel_output_pin_o == (os_running ^ $past(ctrl_q.output_polarity_bit)))
		else $error("pulse level wrong");

	chk_oneshot_read: assert property (
		ar_hs && rsel[0] && oneshot |=> s_axi_rvalid_o && s_axi_rdata_o == 32'h00000000)
		else $error("one-shot read exposed the count");

endmodule // quad_oneshot_timer

`default_nettype wire

// [tb/quad_encoder_model.sv]
`timescale 1ns/100ps
`default_nettype none

// far side: two-phase encoder and Z source, each level held four clocks
module quad_encoder_model (
	// system
	input wire logic clk_i,
	// phases
	output logic phase_a_o,
	output logic phase_b_o,
	output logic zphase_o
);
	logic [1:0] pos_q;

	initial begin
		pos_q = 2'h0;
		phase_a_o = 1'h0;
		phase_b_o = 1'h0;
		zphase_o = 1'h0;
	end

	////////////////////////////////////////////////////////////////////////
	// gray order, b leads a going up
	task automatic move(input int n, input bit up);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_i);
			pos_q = up ? pos_q + 2'h1 : pos_q - 2'h1;
			phase_a_o <= pos_q[1];
			phase_b_o <= pos_q[1] ^ pos_q[0];
			repeat (3) @(posedge clk_i);
		end
	endtask

	task automatic zpulse();
		@(posedge clk_i);
		zphase_o <= 1'h1;
		repeat (4) @(posedge clk_i);
		zphase_o <= 1'h0;
	endtask
endmodule // quad_encoder_model

`default_nettype wire

// [tb/quad_oneshot_timer_tb.sv]
`timescale 1ns/100ps
`default_nettype none

module quad_oneshot_timer_tb;
	logic clk_i, sys_rst_i, awvalid, wvalid, bready, arvalid, rready, awready, wready;
	logic bvalid, arready, rvalid, pin_o, pin_oe, irq, enc_a, enc_b, enc_z, pin_b;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [1:0] bresp, rresp, r;
	logic [2:0] ev;
	int mismatches, n_compared, irq_n, run_len, last_w;

	assign pin_b = pin_oe ? pin_o : enc_b;

	quad_encoder_model enc_u (.clk_i(clk_i), .phase_a_o(enc_a), .phase_b_o(enc_b),
		.zphase_o(enc_z));

	quad_oneshot_timer dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .channel_input_pin_i(enc_a),
		.channel_output_pin_i(pin_b), .zphase_pin_i(enc_z), .channel_output_pin_o(pin_o),
		.channel_output_pin_oe_o(pin_oe), .timer_b_event_i(ev[0]),
		.prev_channel_event_i(ev[1]), .next_channel_event_i(ev[2]), .irq_o(irq));

	initial begin
		clk_i = 1'h0;
		forever #10 clk_i = ~clk_i;
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt pulses and output pulse widths
	always @(posedge clk_i) begin
		if (irq === 1'h1) irq_n++;
		if (pin_o === 1'h1) run_len++;
		else if (run_len != 0) begin
			last_w = run_len;
			run_len = 0;
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		do begin
			@(posedge clk_i);
			if (awvalid && awready) awvalid <= 1'h0;
			if (wvalid && wready) wvalid <= 1'h0;
		end while (bvalid !== 1'h1);
		r = bresp;
	endtask

	task automatic rd(input logic [11:0] a);
		araddr <= a;
		arvalid <= 1'h1;
		do begin
			@(posedge clk_i);
			if (arvalid && arready) arvalid <= 1'h0;
		end while (rvalid !== 1'h1);
		d = rdata;
		r = rresp;
	endtask

	task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string what);
		repeat (10) @(posedge clk_i);
		rd(a);
		chk(what, exp, d);
	endtask

	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk_i);
		mismatches++;
		finish_test();
	end

	initial begin
		{sys_rst_i, bready, rready} = 3'h7;
		{awvalid, wvalid, arvalid, ev, awaddr, araddr, wdata} = '0;
		repeat (12) @(posedge clk_i);
		sys_rst_i <= 1'h0;
		repeat (2) @(posedge clk_i);
		rchk(qtimer_pkg::ADDR_MODE, 32'h0, "mode reset");
		rchk(qtimer_pkg::ADDR_CONTROL, 32'h0, "control reset");
		rchk(qtimer_pkg::ADDR_COUNTER, 32'h0, "counter reset");
		wr(12'h3F0, 32'h5);
		chk("bresp unmapped", 32'(qtimer_pkg::RESP_SLVERR), 32'(r));
		rd(12'h3F0);
		chk("rresp unmapped", 32'(qtimer_pkg::RESP_SLVERR), 32'(r));
		$display("test registers done");
		wr(qtimer_pkg::ADDR_MODE, 32'h11);
		wr(qtimer_pkg::ADDR_COUNTER, 32'h10);
		wr(qtimer_pkg::ADDR_CONTROL, 32'h9);
		enc_u.move(12, 1'b1);
		rchk(qtimer_pkg::ADDR_COUNTER, 32'h13, "normal up");
		enc_u.move(8, 1'b0);
		rchk(qtimer_pkg::ADDR_COUNTER, 32'h11, "normal down");
		wr(qtimer_pkg::ADDR_CONTROL, 32'h8);
		wr(qtimer_pkg::ADDR_COUNTER, 32'hFFFE);
		wr(qtimer_pkg::ADDR_CONTROL, 32'h9);
		enc_u.move(8, 1'b1);
		rchk(qtimer_pkg::ADDR_COUNTER, 32'hFFFE, "reload after two");
		chk("irq count", 32'h1, 32'(irq_n));
		wr(qtimer_pkg::ADDR_COUNTER, 32'h5);
		rchk(qtimer_pkg::ADDR_COUNTER, 32'hFFFE, "running write");
		rchk(qtimer_pkg::ADDR_RELOAD, 32'h5, "reload value");
		enc_u.move(8, 1'b1);
		rchk(qtimer_pkg::ADDR_COUNTER, 32'h5, "new reload");
		$display("test reload type done");
		wr(qtimer_pkg::ADDR_CONTROL, 32'h8);
		wr(qtimer_pkg::ADDR_MODE, 32'hD1);
		wr(qtimer_pkg::ADDR_COUNTER, 32'h0);
		wr(qtimer_pkg::ADDR_CONTROL, 32'h1D);
		enc_u.move(4, 1'b1);
		rchk(qtimer_pkg::ADDR_COUNTER, 32'h4, "x4 up");
		enc_u.zpulse();
		rchk(qtimer_pkg::ADDR_STATUS, 32'h7, "Z pending");
		enc_u.move(4, 1'b1);
		rchk(qtimer_pkg::ADDR_COUNTER, 32'h3, "Z clear");
		enc_u.move(12, 1'b0);
		rchk(qtimer_pkg::ADDR_COUNTER, 32'hFFFB, "x4 free run");
		chk("irq count", 32'h3, 32'(irq_n));
		// Z clear landing on an overflow
		enc_u.move(6, 1'b1);
		enc_u.zpulse();
		enc_u.move(2, 1'b1);
		rchk(qtimer_pkg::ADDR_COUNTER, 32'h1, "Z at overflow");
		chk("double irq", 32'h5, 32'(irq_n));
		$display("test free run done");
		wr(qtimer_pkg::ADDR_CONTROL, 32'h0);
		wr(qtimer_pkg::ADDR_MODE, 32'h6);
		wr(qtimer_pkg::ADDR_COUNTER, 32'h8);
		wr(qtimer_pkg::ADDR_CONTROL, 32'h1);
		last_w = 0;
		wr(qtimer_pkg::ADDR_CONTROL, 32'h3);
		repeat (30) @(posedge clk_i);
		chk("pulse width", 32'h8, 32'(last_w));
		chk("pin enable", 32'h1, 32'(pin_oe));
		chk("irq count", 32'h6, 32'(irq_n));
		rchk(qtimer_pkg::ADDR_COUNTER, 32'(qtimer_pkg::ONESHOT_READ_VALUE), "oneshot read");
		wr(qtimer_pkg::ADDR_MODE, 32'h1E);
		for (int k = 0; k < 4; k++) begin
			wr(qtimer_pkg::ADDR_CONTROL, {24'h0, 2'(k + 1), 6'h1});
			last_w = 0;
			if (k < 3) begin
				ev[k] <= 1'h1;
				@(posedge clk_i);
				ev <= 3'h0;
			end else begin
				enc_u.move(2, 1'b1);
			end
			repeat (30) @(posedge clk_i);
			chk("trigger width", 32'h8, 32'(last_w));
			chk("irq count", 32'(7 + k), 32'(irq_n));
		end
		wr(qtimer_pkg::ADDR_CONTROL, 32'h20);
		repeat (6) @(posedge clk_i);
		chk("inverted idle", 32'h1, 32'(pin_o));
		wr(qtimer_pkg::ADDR_MODE, 32'h46);
		wr(qtimer_pkg::ADDR_CONTROL, 32'h101);
		last_w = 0;
		wr(qtimer_pkg::ADDR_CONTROL, 32'h103);
		repeat (30) @(posedge clk_i);
		chk("extended source", 32'h8, 32'(last_w));
		wr(qtimer_pkg::ADDR_CONTROL, 32'h1);
		last_w = 0;
		wr(qtimer_pkg::ADDR_CONTROL, 32'h3);
		repeat (80) @(posedge clk_i);
		chk("divided source", 32'h7, 32'((last_w - 1) / qtimer_pkg::DIV_SEL1));
		$display("test one-shot done");
		finish_test();
	end
endmodule // quad_oneshot_timer_tb

`default_nettype wire
